// *** crane_fault_pkg.sv ***
// Shared constants and carrier types for the crane travel fault detector.
// Assumes a 32-bit APB master and a 100 MHz system clock.
package crane_fault_pkg;

	// --------------------------------------------------------------
	// Bus widths
	// --------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// --------------------------------------------------------------
	// Register byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_PROT_SEL  = 8'h00;
	localparam logic [7:0] OFS_LIMIT_1   = 8'h04;
	localparam logic [7:0] OFS_LIMIT_2   = 8'h08;
	localparam logic [7:0] OFS_SIGN_SEL  = 8'h0C;
	localparam logic [7:0] OFS_SCALE     = 8'h10;
	localparam logic [7:0] OFS_STOP_POS  = 8'h14;
	localparam logic [7:0] OFS_CONFIG    = 8'h18;
	localparam logic [7:0] OFS_FAULT     = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int unsigned PSEL_RANGE_BIT = 5;
	localparam int unsigned PSEL_LIMIT_BIT = 6;
	localparam int unsigned SIGN_FIRST_BIT = 0;
	localparam int unsigned SIGN_SECOND_BIT = 1;
	localparam int unsigned IRQ_RANGE_BIT  = 0;
	localparam int unsigned IRQ_LIMIT_BIT  = 1;
	localparam int unsigned IRQ_W          = 2;

	// --------------------------------------------------------------
	// Reset values and scale arithmetic
	// --------------------------------------------------------------
	localparam logic [15:0] PROT_SEL_RST   = 16'h0000;
	localparam logic [5:0]  CONFIG_RST     = 6'h10;
	localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
	localparam int unsigned SCALE_MULT_A   = 10;
	localparam int unsigned SCALE_MULT_B   = 4096;
	localparam logic [34:0] SCALE_FACTOR   = 35'(SCALE_MULT_A * SCALE_MULT_B);

	// --------------------------------------------------------------
	// Carrier types
	// --------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_rsp_t;

	// Terminal inputs, active high (switch ON = 1)
	typedef struct packed {
		logic first_end_limit_switch;
		logic second_end_limit_switch;
		logic fwd_run;
		logic rev_run;
		logic start_cmd;
	} term_in_t;

	// Configuration word, bit 5 downward
	typedef struct packed {
		logic absolute_meter;
		logic limit_switch_speed_feed_enable;
		logic second_switch_assigned;
		logic first_switch_assigned;
		logic speed_feed_sel;
		logic position_feed_sel;
	} cfg_t;

endpackage

// *** crane_fault_props.sv ***
// Checker: APB answer timing and fault latching at the detector ports.
// Assumes it is bound onto crane_travel_fault_detect; one clock domain.
`timescale 1ns/100ps
module crane_fault_props (
	// Clock and reset
	input wire logic                      clk_sys,
	input wire logic                      rstn,
	// Bus and terminals
	input wire crane_fault_pkg::apb_req_t apb_req,
	input wire crane_fault_pkg::apb_rsp_t apb_rsp,
	input wire crane_fault_pkg::term_in_t term_in,
	// Outputs
	input wire logic                      range_fault,
	input wire logic                      limit_fault,
	input wire logic                      irq
);
	import crane_fault_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	pready_one_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no pready after setup");
	pready_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("pready outside access");
	pready_single_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	slverr_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0)
		else $error("prdata not zero while idle");
	// ------------------------------------------------------------
	// Faults
	// ------------------------------------------------------------
	range_latch_a: assert property (range_fault |=> range_fault)
		else $error("range fault dropped");
	limit_latch_a: assert property (limit_fault |=> limit_fault)
		else $error("limit fault dropped");
	limit_cause_a: assert property ($rose(limit_fault) |->
		!($past(term_in.first_end_limit_switch, 3) && $past(term_in.second_end_limit_switch, 3)))
		else $error("limit fault with both switches on");
	sync_delay_a: assert property ($rose(rstn) |-> !limit_fault [*3])
		else $error("limit fault before synchroniser filled");
	cover property ($rose(range_fault));
	cover property ($rose(limit_fault));
	cover property (apb_rsp.pslverr);
endmodule // crane_fault_props

bind crane_travel_fault_detect crane_fault_props u_props (.clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .term_in(term_in), .range_fault(range_fault), .limit_fault(limit_fault), .irq(irq));

// *** crane_travel_fault_detect.sv ***
// Crane travel fault detector: stop position range fault and end limit switch fault.
// Assumes an APB master on clk_sys; terminal inputs arrive asynchronously.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps

module crane_travel_fault_detect (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	// APB slave
	input  wire crane_fault_pkg::apb_req_t apb_req,
	output      crane_fault_pkg::apb_rsp_t apb_rsp,
	// Terminals
	input  wire crane_fault_pkg::term_in_t term_in,
	// Fault and interrupt outputs
	output      logic                      range_fault,
	output      logic                      limit_fault,
	output      logic                      irq
);
	import crane_fault_pkg::*;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------

	// Signed motion limit from a magnitude and its sign bit
	function automatic logic signed [34:0] signed_limit(input logic [30:0] mag, input logic neg);
		logic signed [34:0] wide;
		wide = $signed({4'h0, mag});
		signed_limit = neg ? -wide : wide;
	endfunction

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------

	// Register slots reached over the bus
	typedef enum logic [3:0] {
		REG_PROT_SEL,
		REG_LIMIT_1,
		REG_LIMIT_2,
		REG_SIGN_SEL,
		REG_SCALE,
		REG_STOP_POS,
		REG_CONFIG,
		REG_FAULT,
		REG_IRQ_STAT,
		REG_IRQ_MASK,
		REG_NONE
	} reg_sel_t;

	// Shared by the read mux and the write path so both agree on the map
	function automatic reg_sel_t decode_addr(input logic [7:0] a);
		if (a == OFS_PROT_SEL) begin
			decode_addr = REG_PROT_SEL;
		end else if (a == OFS_LIMIT_1) begin
			decode_addr = REG_LIMIT_1;
		end else if (a == OFS_LIMIT_2) begin
			decode_addr = REG_LIMIT_2;
		end else if (a == OFS_SIGN_SEL) begin
			decode_addr = REG_SIGN_SEL;
		end else if (a == OFS_SCALE) begin
			decode_addr = REG_SCALE;
		end else if (a == OFS_STOP_POS) begin
			decode_addr = REG_STOP_POS;
		end else if (a == OFS_CONFIG) begin
			decode_addr = REG_CONFIG;
		end else if (a == OFS_FAULT) begin
			decode_addr = REG_FAULT;
		end else if (a == OFS_IRQ_STAT) begin
			decode_addr = REG_IRQ_STAT;
		end else if (a == OFS_IRQ_MASK) begin
			decode_addr = REG_IRQ_MASK;
		end else begin
			decode_addr = REG_NONE;
		end
	endfunction

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [15:0] prot_sel;
		logic [30:0] limit_first;
		logic [30:0] limit_second;
		logic [1:0]  sign_sel;
		logic [15:0] scale;
		logic [31:0] stop_pos;
		logic        stop_written;
		cfg_t        cfg;
		logic        range_fault;
		logic        limit_fault;
		apb_rsp_t    rsp;
	} core_state_t;

	core_state_t state_ff;
	core_state_t nxt_state;

	// --------------------------------------------------------------
	// Terminal synchronisation
	// --------------------------------------------------------------
	term_in_t term_s;

	// Switches come from the terminal pins only; no link path exists
	term_sync u_term_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.raw_in   (term_in),
		.sync_out (term_s)
	);

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	logic             setup_ph;
	logic             wr_acc;
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic [31:0]      rd_word;
	logic             rd_miss;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_set;
	logic             mask_we;
	reg_sel_t         sel;

	assign setup_ph = apb_req.psel & ~apb_req.penable;
	assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite & state_ff.rsp.pready;
	assign addr     = apb_req.paddr;
	assign wdata    = apb_req.pwdata;
	assign sel      = decode_addr(addr);
	assign mask_we  = wr_acc && (sel == REG_IRQ_MASK);
	assign irq_clr  = (wr_acc && (sel == REG_IRQ_STAT)) ? wdata[IRQ_W-1:0] : '0;

	// Read mux, sampled in the setup cycle
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_miss = 1'b0;
		if (sel == REG_PROT_SEL) begin
			rd_word = {16'h0000, state_ff.prot_sel};
		end else if (sel == REG_LIMIT_1) begin
			rd_word = {1'b0, state_ff.limit_first};
		end else if (sel == REG_LIMIT_2) begin
			rd_word = {1'b0, state_ff.limit_second};
		end else if (sel == REG_SIGN_SEL) begin
			rd_word = {30'h0000_0000, state_ff.sign_sel};
		end else if (sel == REG_SCALE) begin
			rd_word = {16'h0000, state_ff.scale};
		end else if (sel == REG_STOP_POS) begin
			rd_word = state_ff.stop_pos;
		end else if (sel == REG_CONFIG) begin
			rd_word = {26'h000_0000, state_ff.cfg};
		end else if (sel == REG_FAULT) begin
			rd_word = {29'h0000_0000, state_ff.stop_written, state_ff.limit_fault,
				state_ff.range_fault};
		end else if (sel == REG_IRQ_STAT) begin
			rd_word = {30'h0000_0000, irq_status};
		end else if (sel == REG_IRQ_MASK) begin
			rd_word = {30'h0000_0000, irq_mask};
		end else begin
			rd_miss = 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Motion range evaluation
	// --------------------------------------------------------------
	logic signed [34:0] lower_lim;
	logic signed [34:0] upper_lim;
	logic signed [34:0] span;
	logic signed [34:0] stop_val;
	logic [34:0]        scale_span;
	logic               range_armed;
	logic               range_eval;
	logic               cmd_outside;
	logic               lim_inverted;
	logic               scale_short;
	logic               range_hit;

	// Each limit is a magnitude with its own sign bit; widened so span cannot wrap
	assign lower_lim  = signed_limit(state_ff.limit_first, state_ff.sign_sel[SIGN_FIRST_BIT]);
	assign upper_lim  = signed_limit(state_ff.limit_second, state_ff.sign_sel[SIGN_SECOND_BIT]);
	assign span       = upper_lim - lower_lim;
	assign stop_val   = 35'(signed'(state_ff.stop_pos));
	assign scale_span = 35'({19'h0_0000, state_ff.scale} * SCALE_FACTOR);

	assign range_armed  = state_ff.prot_sel[PSEL_RANGE_BIT];
	assign range_eval   = state_ff.cfg.position_feed_sel
		&& (term_s.start_cmd || state_ff.stop_written);
	assign cmd_outside  = state_ff.stop_written
		&& ((stop_val < lower_lim) || (stop_val > upper_lim));
	assign lim_inverted = lower_lim > upper_lim;
	assign scale_short  = state_ff.cfg.absolute_meter
		&& ($signed(scale_span) < span);
	assign range_hit    = range_armed && range_eval
		&& (cmd_outside || lim_inverted || scale_short);

	// --------------------------------------------------------------
	// Limit switch evaluation
	// --------------------------------------------------------------
	logic limit_armed;
	logic feed_sel;
	logic sw_en;
	logic one_sw_mode;
	logic two_sw_mode;
	logic one_sw_avail;
	logic two_sw_avail;
	logic one_sw_trip;
	logic two_sw_trip;
	logic limit_hit;

	assign limit_armed = state_ff.prot_sel[PSEL_LIMIT_BIT];
	assign feed_sel    = state_ff.cfg.position_feed_sel | state_ff.cfg.speed_feed_sel;
	assign sw_en       = state_ff.cfg.limit_switch_speed_feed_enable;
	assign one_sw_mode = state_ff.cfg.first_switch_assigned & ~state_ff.cfg.second_switch_assigned;
	assign two_sw_mode = state_ff.cfg.first_switch_assigned & state_ff.cfg.second_switch_assigned;

	assign one_sw_avail = (sw_en && feed_sel) || one_sw_mode;
	assign two_sw_avail = (sw_en && feed_sel) || two_sw_mode;

	// Switch OFF means the input reads low
	assign one_sw_trip = one_sw_mode && one_sw_avail
		&& !term_s.first_end_limit_switch;
	assign two_sw_trip = two_sw_mode && two_sw_avail
		&& ((!term_s.first_end_limit_switch && term_s.fwd_run)
		|| (!term_s.second_end_limit_switch && term_s.rev_run));

	assign limit_hit = limit_armed && (one_sw_trip || two_sw_trip);

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// Register writes at the completing access edge
		if (wr_acc) begin
			if (sel == REG_PROT_SEL) begin
				nxt_state.prot_sel = wdata[15:0];
			end else if (sel == REG_LIMIT_1) begin
				nxt_state.limit_first = wdata[30:0];
			end else if (sel == REG_LIMIT_2) begin
				nxt_state.limit_second = wdata[30:0];
			end else if (sel == REG_SIGN_SEL) begin
				nxt_state.sign_sel = wdata[1:0];
			end else if (sel == REG_SCALE) begin
				nxt_state.scale = wdata[15:0];
			end else if (sel == REG_STOP_POS) begin
				nxt_state.stop_pos     = wdata;
				nxt_state.stop_written = 1'b1;
			end else if (sel == REG_CONFIG) begin
				nxt_state.cfg = cfg_t'(wdata[5:0]);
			end
		end

		// Faults only set; nothing but reset clears them
		nxt_state.range_fault = state_ff.range_fault | range_hit;
		nxt_state.limit_fault = state_ff.limit_fault | limit_hit;

		// Registered response: ready in the first access cycle
		nxt_state.rsp.pready  = setup_ph;
		nxt_state.rsp.pslverr = setup_ph & rd_miss;
		// Writes and idle cycles return zero data
		nxt_state.rsp.prdata  = 32'h0000_0000;
		if (setup_ph && !apb_req.pwrite) begin
			nxt_state.rsp.prdata = rd_word;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff          <= '0;
			state_ff.prot_sel <= PROT_SEL_RST;
			state_ff.cfg      <= cfg_t'(CONFIG_RST);
		end else begin
			state_ff <= nxt_state;
		end
	end

	// --------------------------------------------------------------
	// Interrupts
	// --------------------------------------------------------------
	logic [IRQ_W-1:0] fault_now;
	logic [IRQ_W-1:0] fault_nxt;

	always_comb begin
		fault_now                = '0;
		fault_nxt                = '0;
		fault_now[IRQ_RANGE_BIT] = state_ff.range_fault;
		fault_nxt[IRQ_RANGE_BIT] = nxt_state.range_fault;
		fault_now[IRQ_LIMIT_BIT] = state_ff.limit_fault;
		fault_nxt[IRQ_LIMIT_BIT] = nxt_state.limit_fault;
	end

	// One event per fault, only on the cycle it first latches
	for (genvar i = 0; i < IRQ_W; i++) begin : g_fault_rise
		assign irq_set[i] = fault_nxt[i] & ~fault_now[i];
	end

	irq_bank u_irq_bank (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.set_evt    (irq_set),
		.clr_bits   (irq_clr),
		.mask_we    (mask_we),
		.mask_wdata (wdata[IRQ_W-1:0]),
		.status     (irq_status),
		.mask       (irq_mask),
		.irq        (irq)
	);

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign apb_rsp     = state_ff.rsp;
	assign range_fault = state_ff.range_fault;
	assign limit_fault = state_ff.limit_fault;

endmodule // crane_travel_fault_detect

// *** irq_bank.sv ***
// Sticky event flags with write-one-to-clear, a mask and one level interrupt.
// Assumes set and clear strobes are single-cycle and on clk_sys.
`timescale 1ns/100ps
module irq_bank (
	// Clock and reset
	input  wire logic                               clk_sys,
	input  wire logic                               rstn,
	// Events and software access
	input  wire logic [crane_fault_pkg::IRQ_W-1:0] set_evt,
	input  wire logic [crane_fault_pkg::IRQ_W-1:0] clr_bits,
	input  wire logic                               mask_we,
	input  wire logic [crane_fault_pkg::IRQ_W-1:0] mask_wdata,
	// State
	output      logic [crane_fault_pkg::IRQ_W-1:0] status,
	output      logic [crane_fault_pkg::IRQ_W-1:0] mask,
	output      logic                               irq
);
	import crane_fault_pkg::*;

	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic             irq;
	} irq_state_t;

	irq_state_t state_ff;
	irq_state_t nxt_state;

	always_comb begin
		nxt_state        = state_ff;
		// Set wins over a clear in the same cycle
		nxt_state.status = (state_ff.status & ~clr_bits) | set_evt;
		if (mask_we) begin
			nxt_state.mask = mask_wdata;
		end
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff      <= '0;
			state_ff.mask <= IRQ_MASK_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign status = state_ff.status;
	assign mask   = state_ff.mask;
	assign irq    = state_ff.irq;

endmodule // irq_bank

// *** switch_field.sv ***
// Field side model: limit switch contacts and run command terminals.
// Assumes the bench commands levels on clk_sys; contacts settle off the edge.
`timescale 1ns/100ps
module switch_field (
	// Clock
	input wire logic                      clk_sys,
	// Commanded levels and pin levels
	input wire crane_fault_pkg::term_in_t cmd,
	output     crane_fault_pkg::term_in_t pins
);
	import crane_fault_pkg::*;
	initial pins = '0;
	// Contacts move a few ns after the edge, unrelated to sampling
	always @(posedge clk_sys) begin
		pins <= #3 cmd;
	end
endmodule // switch_field

// *** term_sync.sv ***
// Two-stage synchroniser for the terminal inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/100ps
module term_sync (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	// Raw and synchronised terminals
	input  wire crane_fault_pkg::term_in_t raw_in,
	output      crane_fault_pkg::term_in_t sync_out
);
	import crane_fault_pkg::*;

	typedef struct packed {
		term_in_t meta;
		term_in_t stable;
	} sync_state_t;

	sync_state_t state_ff;
	sync_state_t nxt_state;

	always_comb begin
		nxt_state        = state_ff;
		nxt_state.meta   = raw_in;
		nxt_state.stable = state_ff.meta;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sync_out = state_ff.stable;

endmodule // term_sync

// *** testbench.sv ***
// Testbench: table of settings, each checked through the fault status word.
// Assumes the package, design, checker and switch model are compiled first.
`timescale 1ns/100ps
module testbench;
	import crane_fault_pkg::*;
	logic        clk_sys;
	logic        rstn;
	apb_req_t    req;
	apb_rsp_t    rsp;
	term_in_t    cmd;
	term_in_t    pins;
	logic        range_fault;
	logic        limit_fault;
	logic        irq;
	logic [32:0] expq[$];
	logic [31:0] seed;
	logic [31:0] sp;
	int          num_errors;
	int          n_tests;
	int          cycles;
	crane_travel_fault_detect dut (.clk_sys(clk_sys), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
		.term_in(pins), .range_fault(range_fault), .limit_fault(limit_fault), .irq(irq));
	switch_field u_sw (.clk_sys(clk_sys), .cmd(cmd), .pins(pins));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		if (!w) expq.push_back(e);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n == 20) chk("pready", 33'h1, 33'h0);
		req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		xfer(1'b0, a, 32'h0, e);
	endtask
	task automatic rst();
		rstn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask
	task automatic run(input logic [15:0] p, input logic [1:0] sg, input logic [31:0] l1, input logic [31:0] l2,
		input logic [15:0] sc, input logic [5:0] cf, input logic se, input logic [31:0] st, input term_in_t t,
		input logic [2:0] ex);
		cmd <= t;
		rst();
		wr(OFS_PROT_SEL, {16'h0, p});
		wr(OFS_SIGN_SEL, {30'h0, sg});
		wr(OFS_LIMIT_1, l1);
		wr(OFS_LIMIT_2, l2);
		wr(OFS_SCALE, {16'h0, sc});
		wr(OFS_CONFIG, {26'h0, cf});
		if (se) wr(OFS_STOP_POS, st);
		repeat (6) @(posedge clk_sys);
		rd(OFS_FAULT, {30'h0, ex});
		chk("range_fault", {32'h0, ex[0]}, {32'h0, range_fault});
		chk("limit_fault", {32'h0, ex[1]}, {32'h0, limit_fault});
		$display("case done, fault word %h", ex);
	endtask
	// ------------------------------------------------------------
	// Result watcher and timeout
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && expq.size() > 0) begin
			chk("prdata", expq.pop_front(), {rsp.pslverr, rsp.prdata});
		end
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			chk("timeout", 33'h0, 33'h1);
			test_done();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		req = '0;
		cmd = 5'h18;
		seed = 32'h26;
		num_errors = 0;
		n_tests = 0;
		cycles = 0;
		rst();
		rd(OFS_CONFIG, 33'h10);
		rd(OFS_PROT_SEL, 33'h0);
		rd(OFS_IRQ_MASK, 33'h0);
		rd(OFS_FAULT, 33'h0);
		rd(8'h40, {1'b1, 32'h0});
		$display("reset values done");
		run(16'h20, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, 32'h3E9, 5'h18, 3'h5);
		run(16'h00, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, 32'h3E9, 5'h18, 3'h4);
		run(16'h20, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, 32'hFFFFFF9C, 5'h18, 3'h4);
		run(16'h20, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, 32'hFFFFFF9B, 5'h18, 3'h5);
		run(16'h20, 2'h3, 32'h3E8, 32'h64, 16'h0, 6'h11, 1'b1, 32'hFFFFFFCE, 5'h18, 3'h5);
		run(16'h20, 2'h0, 32'h1F4, 32'h64, 16'h0, 6'h11, 1'b0, 32'h0, 5'h19, 3'h1);
		run(16'h20, 2'h0, 32'h1F4, 32'h64, 16'h0, 6'h10, 1'b0, 32'h0, 5'h19, 3'h0);
		run(16'h20, 2'h0, 32'h1F4, 32'h64, 16'h0, 6'h11, 1'b0, 32'h0, 5'h18, 3'h0);
		run(16'h20, 2'h0, 32'h0, 32'hC350, 16'h1, 6'h31, 1'b0, 32'h0, 5'h19, 3'h1);
		run(16'h20, 2'h0, 32'h0, 32'hC350, 16'h2, 6'h31, 1'b0, 32'h0, 5'h19, 3'h0);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h15, 1'b0, 32'h0, 5'h08, 3'h2);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h11, 1'b0, 32'h0, 5'h08, 3'h0);
		run(16'h00, 2'h0, 32'h0, 32'h0, 16'h0, 6'h15, 1'b0, 32'h0, 5'h08, 3'h0);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h04, 1'b0, 32'h0, 5'h08, 3'h2);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h1D, 1'b0, 32'h0, 5'h0A, 3'h0);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h1D, 1'b0, 32'h0, 5'h0C, 3'h2);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h1D, 1'b0, 32'h0, 5'h12, 3'h2);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h1D, 1'b0, 32'h0, 5'h14, 3'h0);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h0C, 1'b0, 32'h0, 5'h0C, 3'h2);
		run(16'h40, 2'h0, 32'h0, 32'h0, 16'h0, 6'h1E, 1'b0, 32'h0, 5'h0C, 3'h2);
		run(16'h60, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h15, 1'b1, 32'h3E9, 5'h08, 3'h7);
		for (int i = 0; i < 3; i++) begin
			sp = (rnd() % 32'h44D) - 32'h64;
			run(16'h20, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, sp, 5'h18, 3'h4);
		end
		run(16'h20, 2'h1, 32'h64, 32'h3E8, 16'h0, 6'h11, 1'b1, 32'h3E9, 5'h18, 3'h5);
		chk("irq", 33'h0, {32'h0, irq});
		wr(OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk("irq", 33'h1, {32'h0, irq});
		rd(OFS_IRQ_STAT, 33'h1);
		wr(OFS_IRQ_STAT, 32'h1);
		rd(OFS_IRQ_STAT, 33'h0);
		wr(OFS_STOP_POS, 32'h5);
		wr(OFS_FAULT, 32'h0);
		rd(OFS_FAULT, 33'h5);
		chk("irq", 33'h0, {32'h0, irq});
		$display("latch and interrupt done");
		repeat (4) @(posedge clk_sys);
		test_done();
	end
endmodule // testbench
